// file: core/cxs_cfg.svh
// Purpose: Offsets, field positions and reset values of the pin router
// Assumes: Eight-bit special function register port, sixteen routed pins
// Notes: Definitions only
`ifndef CXS_CFG_SVH
`define CXS_CFG_SVH

`define CXS_OFS_ROUTE_A 8'hE1
`define CXS_OFS_ROUTE_B 8'hE2
`define CXS_RST_ROUTE_A 8'h00
`define CXS_RST_ROUTE_B 8'h00

`define CXS_A_UART 0
`define CXS_A_CAN 1
`define CXS_A_SPI 2
`define CXS_A_SMB 3
`define CXS_A_CP0 4
`define CXS_A_CP0A 5
`define CXS_A_CP1 6
`define CXS_A_CP1A 7

`define CXS_B_SYSCK 1
`define CXS_B_CAP_LO 2
`define CXS_B_CAP_HI 4
`define CXS_B_ECI 5
`define CXS_B_T0 6
`define CXS_B_T1 7

`define CXS_CAP_RESERVED 3'h7

`define CXS_PIN_UART_TX 4
`define CXS_PIN_UART_RX 5
`define CXS_PIN_CAN_TX 6
`define CXS_PIN_CAN_RX 7

`define CXS_PERIPH_IN_IDLE 1'h1

`endif

// file: core/cxs_pkg.sv
// Purpose: Types shared by the pin router and its allocator
// Assumes: Sixteen pins, twenty-four routable signals plus the none code
// Notes: Signal code order is the crossbar priority order
package cxs_pkg;

    localparam int CXS_PINS = 16;
    localparam int CXS_RES = 25;

    typedef enum logic [4:0]
    {
        CXS_NONE = 5'h00,
        CXS_UART_TX = 5'h01,
        CXS_UART_RX = 5'h02,
        CXS_CAN_TX = 5'h03,
        CXS_CAN_RX = 5'h04,
        CXS_SPI_SCK = 5'h05,
        CXS_SPI_MISO = 5'h06,
        CXS_SPI_MOSI = 5'h07,
        CXS_SPI_NSS = 5'h08,
        CXS_SMB_SDA = 5'h09,
        CXS_SMB_SCL = 5'h0A,
        CXS_CMP0 = 5'h0B,
        CXS_CMP0_ASYNC = 5'h0C,
        CXS_CMP1 = 5'h0D,
        CXS_CMP1_ASYNC = 5'h0E,
        CXS_SYSCLK = 5'h0F,
        CXS_CAP0 = 5'h10,
        CXS_CAP1 = 5'h11,
        CXS_CAP2 = 5'h12,
        CXS_CAP3 = 5'h13,
        CXS_CAP4 = 5'h14,
        CXS_CAP5 = 5'h15,
        CXS_ECI = 5'h16,
        CXS_TMR0 = 5'h17,
        CXS_TMR1 = 5'h18
    } cxs_res_t;

    typedef logic [CXS_PINS-1:0][4:0] cxs_map_t;

    typedef struct packed
    {
        logic [CXS_RES-1:0] out;
        logic [CXS_RES-1:0] oe;
    } cxs_periph_t;

    typedef struct packed
    {
        logic [CXS_PINS-1:0] out;
        logic [CXS_PINS-1:0] oe;
    } cxs_pins_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic wr_en;
        logic [7:0] wdata;
    } cxs_sfr_req_t;

    typedef struct packed
    {
        cxs_map_t map;
        logic [CXS_RES-1:0] placed;
    } cxs_alloc_st_t;

    typedef struct packed
    {
        logic [7:0] route_select_a;
        logic [7:0] route_select_b;
        logic [7:0] rdata;
        logic [CXS_PINS-1:0] pin_meta;
        logic [CXS_PINS-1:0] pin_sync;
        cxs_pins_t pins;
        logic [CXS_RES-1:0] periph_in;
    } cxs_st_t;

endpackage

// file: core/cxs_pin_alloc.sv
// Purpose: Priority allocator, gives requested signals free pins in priority order
// Assumes: Requests and skip mask on the core clock
// Notes: Map and placement flags come out of registers
`timescale 1ns/1ps
`include "cxs_cfg.svh"

module cxs_pin_alloc
    import cxs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [CXS_RES-1:0] req,
    input wire logic [CXS_PINS-1:0] pin_skip_mask,
    output cxs_map_t map,
    output logic [CXS_RES-1:0] placed
);

    cxs_alloc_st_t st;
    cxs_alloc_st_t next_st;

    function automatic logic is_fixed(input int r);
        return (r >= int'(CXS_UART_TX)) && (r <= int'(CXS_CAN_RX));
    endfunction

    always_comb
    begin
        logic [CXS_PINS-1:0] taken;
        logic found;
        logic pair_ok;
        taken = pin_skip_mask;
        found = 1'b0;
        pair_ok = 1'b1;
        next_st = '0;
        // Fixed pins win over skip bits and are claimed in pairs
        if (req[CXS_UART_TX])
        begin
            next_st.map[`CXS_PIN_UART_TX] = CXS_UART_TX;
            next_st.map[`CXS_PIN_UART_RX] = CXS_UART_RX;
            taken[`CXS_PIN_UART_TX] = 1'b1;
            taken[`CXS_PIN_UART_RX] = 1'b1;
            next_st.placed[CXS_UART_TX] = 1'b1;
            next_st.placed[CXS_UART_RX] = 1'b1;
        end
        if (req[CXS_CAN_TX])
        begin
            next_st.map[`CXS_PIN_CAN_TX] = CXS_CAN_TX;
            next_st.map[`CXS_PIN_CAN_RX] = CXS_CAN_RX;
            taken[`CXS_PIN_CAN_TX] = 1'b1;
            taken[`CXS_PIN_CAN_RX] = 1'b1;
            next_st.placed[CXS_CAN_TX] = 1'b1;
            next_st.placed[CXS_CAN_RX] = 1'b1;
        end
        // Lowest free pin, in priority order; each half of a pair takes the next free pin
        for (int r = 1; r < CXS_RES; r++)
        begin
            found = 1'b0;
            // Two-wire bus needs two free pins, else neither half lands
            if (r == int'(CXS_SMB_SDA))
            begin
                pair_ok = $countones(~taken) > 1;
            end
            if (req[r] && !is_fixed(r)
                && (pair_ok || (r != int'(CXS_SMB_SDA)
                && r != int'(CXS_SMB_SCL))))
            begin
                for (int p = 0; p < CXS_PINS; p++)
                begin
                    if (!found && !taken[p])
                    begin
                        next_st.map[p] = 5'(r);
                        taken[p] = 1'b1;
                        found = 1'b1;
                    end
                end
            end
            // Signals that find no free pin stay off the port
            next_st.placed[r] = next_st.placed[r] | found;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign map = st.map;
    assign placed = st.placed;

endmodule

// file: core/cxs_crossbar_select.sv
// Purpose: Crossbar routing registers and pin multiplexer
// Assumes: Special function register port on the core clock
// Notes: Global enable and skip mask come from neighbouring registers
//
// Summary of operation
// - Uart enable puts transmit and receive on pins 4 and 5 of port 0.
// - Can enable puts transmit and receive on pins 6 and 7; else unrouted.
// - Spi enable routes three or four signals, per wire mode.
// - Two-wire bus enable routes data and clock; else neither appears.
// - Each comparator synchronous output routed only while its bit is one.
// - Each comparator asynchronous output routed only while its bit is one.
// - Timer 1 and timer 0 inputs routed independently by their bits.
// - Counter array external clock input routed only while its bit is set.
// - Capture field routes modules 0..N-1; zero none; seven reserved.
// - System clock output drives a pin only while its bit is set.
// - No routing until global enable; pins stay inputs before then.
// - Unfixed signals get lowest free unskipped pin in priority order.
// - Two-signal peripherals claim both pins together.
`timescale 1ns/1ps
`include "cxs_cfg.svh"

module cxs_crossbar_select
    import cxs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input cxs_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic crossbar_global_en,
    input wire logic [CXS_PINS-1:0] pin_skip_mask,
    input wire logic spi_four_wire,
    input cxs_periph_t periph,
    output logic [CXS_RES-1:0] periph_in,
    output logic [CXS_RES-1:0] periph_placed,
    input cxs_pins_t gpio,
    input wire logic [CXS_PINS-1:0] pin_in,
    output logic [CXS_PINS-1:0] pin_out,
    output logic [CXS_PINS-1:0] pin_oe
);

    cxs_st_t st;
    cxs_st_t next_st;
    logic [CXS_RES-1:0] req;
    cxs_map_t map;
    logic [CXS_RES-1:0] placed;

    // Open-drain signals only ever pull low
    function automatic logic is_open_drain(input logic [4:0] r);
        return (r == CXS_SMB_SDA) || (r == CXS_SMB_SCL);
    endfunction

    function automatic logic bit_a(input logic [7:0] v, input int b);
        return v[b];
    endfunction

    // Request vector in priority order
    always_comb
    begin
        logic [2:0] cap;
        cap = st.route_select_b[`CXS_B_CAP_HI:`CXS_B_CAP_LO];
        req = '0;
        req[CXS_UART_TX] = bit_a(st.route_select_a, `CXS_A_UART);
        req[CXS_UART_RX] = bit_a(st.route_select_a, `CXS_A_UART);
        req[CXS_CAN_TX] = bit_a(st.route_select_a, `CXS_A_CAN);
        req[CXS_CAN_RX] = bit_a(st.route_select_a, `CXS_A_CAN);
        req[CXS_SPI_SCK] = bit_a(st.route_select_a, `CXS_A_SPI);
        req[CXS_SPI_MISO] = bit_a(st.route_select_a, `CXS_A_SPI);
        req[CXS_SPI_MOSI] = bit_a(st.route_select_a, `CXS_A_SPI);
        req[CXS_SPI_NSS] = bit_a(st.route_select_a, `CXS_A_SPI)
            & spi_four_wire;
        req[CXS_SMB_SDA] = bit_a(st.route_select_a, `CXS_A_SMB);
        req[CXS_SMB_SCL] = bit_a(st.route_select_a, `CXS_A_SMB);
        req[CXS_CMP0] = bit_a(st.route_select_a, `CXS_A_CP0);
        req[CXS_CMP0_ASYNC] = bit_a(st.route_select_a, `CXS_A_CP0A);
        req[CXS_CMP1] = bit_a(st.route_select_a, `CXS_A_CP1);
        req[CXS_CMP1_ASYNC] = bit_a(st.route_select_a, `CXS_A_CP1A);
        req[CXS_SYSCLK] = bit_a(st.route_select_b, `CXS_B_SYSCK);
        // Reserved code routes nothing rather than guessing a count
        if (cap != `CXS_CAP_RESERVED)
        begin
            for (int m = 0; m < 6; m++)
            begin
                if (m < int'(cap))
                begin
                    req[int'(CXS_CAP0) + m] = 1'b1;
                end
            end
        end
        req[CXS_ECI] = bit_a(st.route_select_b, `CXS_B_ECI);
        req[CXS_TMR0] = bit_a(st.route_select_b, `CXS_B_T0);
        req[CXS_TMR1] = bit_a(st.route_select_b, `CXS_B_T1);
    end

    cxs_pin_alloc u_alloc
    (
        .clk(clk),
        .rst_b(rst_b),
        .req(req),
        .pin_skip_mask(pin_skip_mask),
        .map(map),
        .placed(placed)
    );

    always_comb
    begin
        logic [4:0] sel;
        sel = CXS_NONE;
        next_st = st;

        // Register port; reads answer one cycle after the address
        if (sfr_req.wr_en && sfr_req.addr == `CXS_OFS_ROUTE_A)
        begin
            next_st.route_select_a = sfr_req.wdata;
        end
        if (sfr_req.wr_en && sfr_req.addr == `CXS_OFS_ROUTE_B)
        begin
            next_st.route_select_b = sfr_req.wdata;
        end
        unique case (sfr_req.addr)
            `CXS_OFS_ROUTE_A: next_st.rdata = st.route_select_a;
            `CXS_OFS_ROUTE_B: next_st.rdata = st.route_select_b;
            default: next_st.rdata = 8'h00;
        endcase

        // Pins are asynchronous to the core, two stages before use
        next_st.pin_meta = pin_in;
        next_st.pin_sync = st.pin_meta;

        next_st.periph_in = {CXS_RES{`CXS_PERIPH_IN_IDLE}};
        for (int p = 0; p < CXS_PINS; p++)
        begin
            sel = map[p];
            if (!crossbar_global_en)
            begin
                // Drivers off while disabled: plain input pins
                next_st.pins.out[p] = 1'b0;
                next_st.pins.oe[p] = 1'b0;
            end
            else if (sel == CXS_NONE)
            begin
                next_st.pins.out[p] = gpio.out[p];
                next_st.pins.oe[p] = gpio.oe[p];
            end
            else if (is_open_drain(sel))
            begin
                // Drive low only; high comes from the pull-up
                next_st.pins.out[p] = 1'b0;
                next_st.pins.oe[p] = periph.oe[sel] & ~periph.out[sel];
                next_st.periph_in[sel] = st.pin_sync[p];
            end
            else
            begin
                next_st.pins.out[p] = periph.out[sel];
                next_st.pins.oe[p] = periph.oe[sel];
                next_st.periph_in[sel] = st.pin_sync[p];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.route_select_a <= `CXS_RST_ROUTE_A;
            st.route_select_b <= `CXS_RST_ROUTE_B;
            st.periph_in <= {CXS_RES{`CXS_PERIPH_IN_IDLE}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign pin_out = st.pins.out;
    assign pin_oe = st.pins.oe;
    assign periph_in = st.periph_in;
    assign periph_placed = placed & {CXS_RES{crossbar_global_en}};

endmodule

// file: sim/cxs_crossbar_select_monitor.sv
// Purpose: Port assertions for the crossbar select block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module cxs_crossbar_select_monitor
    import cxs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input cxs_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic crossbar_global_en,
    input wire logic spi_four_wire,
    input cxs_periph_t periph,
    input wire logic [CXS_RES-1:0] periph_placed,
    input wire logic [CXS_PINS-1:0] pin_out,
    input wire logic [CXS_PINS-1:0] pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_uart_fixed: assert property (
        periph_placed[1] |=> pin_out[4] == $past(periph.out[1])
        && pin_oe[4] == $past(periph.oe[1]))
        else $error("uart transmit not on its fixed pin");
    a_can_fixed: assert property (
        periph_placed[3] |=> pin_out[6] == $past(periph.out[3])
        && pin_oe[6] == $past(periph.oe[3]))
        else $error("can transmit not on its fixed pin");
    a_global_off: assert property (
        !crossbar_global_en |-> periph_placed == '0 ##1 pin_oe == '0)
        else $error("pins driven while crossbar disabled");
    a_pair_claim: assert property (
        periph_placed[1] == periph_placed[2]
        && periph_placed[3] == periph_placed[4]
        && periph_placed[9] == periph_placed[10])
        else $error("paired signals placed apart");
    a_reset_clear: assert property (
        $rose(rst_b) |-> sfr_rdata == 8'h00 && periph_placed == '0)
        else $error("state not clear after reset");
    a_cap_cumul: assert property (
        ((periph_placed[21:16] + 6'h01) & periph_placed[21:16]) == 6'h00)
        else $error("capture pins not a contiguous run");
    a_spi_nss: assert property (
        periph_placed[8] |-> $past(spi_four_wire))
        else $error("select pin routed in three-wire mode");
    a_cap_reserved: assert property (
        sfr_req.wr_en && sfr_req.addr == 8'hE2 && sfr_req.wdata[4:2] == 3'h7
        |-> ##2 periph_placed[21:16] == 6'h00)
        else $error("reserved capture code routed pins");
endmodule

bind cxs_crossbar_select cxs_crossbar_select_monitor u_mon (.*);

// file: sim/cxs_periph_model.sv
// Purpose: Peripherals and pads on the far side of the crossbar
// Assumes: A driven pad reads back its own level
// Notes: Undriven pads take the outside level the bench picks
`timescale 1ns/1ps
module cxs_periph_model
    import cxs_pkg::*;
(
    input wire logic [CXS_RES-1:0] drv_val,
    input wire logic [CXS_RES-1:0] drv_en,
    input wire logic [CXS_PINS-1:0] ext_level,
    input wire logic [CXS_PINS-1:0] pin_out,
    input wire logic [CXS_PINS-1:0] pin_oe,
    output cxs_periph_t periph,
    output logic [CXS_PINS-1:0] pin_in
);
    // Outside level changes every pass, so stale values cannot pass
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    assign periph = '{out: drv_val, oe: drv_en};
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the crossbar select block
// Assumes: 20 MHz clock, reset held eight cycles
// Notes: Skip mask kept light so paired signals always fit
`timescale 1ns/1ps
module tb_top;
    import cxs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    cxs_sfr_req_t sfr_req = '0;
    logic en = 1'b0;
    logic fw = 1'b0;
    logic [15:0] skip = '0;
    logic [15:0] ext = '0;
    logic [24:0] pv = '0;
    logic [24:0] pe = '0;
    cxs_pins_t gpio = '0;
    cxs_periph_t periph;
    logic [7:0] rdata;
    logic [24:0] p_in, placed, ep, ei;
    logic [15:0] pin_in, pin_out, pin_oe, eo, ee;
    logic [7:0] ra, rb;
    logic [31:0] r;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'h076f;
    int own[16];

    always #25 clk = ~clk;

    cxs_crossbar_select DUT (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req),
        .sfr_rdata(rdata), .crossbar_global_en(en), .pin_skip_mask(skip),
        .spi_four_wire(fw), .periph(periph), .periph_in(p_in),
        .periph_placed(placed), .gpio(gpio), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    cxs_periph_model u_far (.drv_val(pv), .drv_en(pe), .ext_level(ext),
        .pin_out(pin_out), .pin_oe(pin_oe), .periph(periph), .pin_in(pin_in));

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [24:0] got, input logic [24:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{addr: a, wr_en: 1'b1, wdata: d};
        @(posedge clk);
        sfr_req.wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_req <= '{addr: a, wr_en: 1'b0, wdata: 8'h00};
        @(posedge clk);
        #1 chk_reg(rdata, exp);
    endtask

    // Greedy allocation in code order, fixed pins first by priority
    task automatic model();
        logic [24:0] rq;
        int n;
        int q;
        int c;
        rq = {rb[7:5], 6'h00, rb[1], ra[7:4], {2{ra[3]}}, ra[2] & fw,
              {3{ra[2]}}, {2{ra[1]}}, {2{ra[0]}}, 1'b0};
        n = rb[4:2];
        for (int k = 0; k < 6; k++)
            rq[16 + k] = (k < n) && (n != 7);
        ep = '0;
        ei = '1;
        for (int p = 0; p < 16; p++)
            own[p] = 0;
        for (int k = 1; k < 25; k++)
        begin
            q = -1;
            if (k < 5)
                q = k + 3;
            for (int p = 0; p < 16; p++)
                if (q < 0 && !skip[p] && own[p] == 0)
                    q = p;
            if (rq[k] && q >= 0)
            begin
                own[q] = k;
                ep[k] = en;
            end
        end
        for (int p = 0; p < 16; p++)
        begin
            c = own[p];
            {eo[p], ee[p]} = {gpio.out[p] & en, gpio.oe[p] & en};
            if (en && (c == 9 || c == 10))
                {eo[p], ee[p]} = {1'b0, pe[c] & ~pv[c]};
            else if (en && c != 0)
                {eo[p], ee[p]} = {pv[c], pe[c]};
            if (en && c != 0)
                ei[c] = ee[p] ? eo[p] : ext[p];
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'hE1, 8'h00);
        rd(8'hE2, 8'h00);
        for (int i = 0; i < 48; i++)
        begin
            r = $random(seed);
            ra = r[7:0];
            rb = {r[15:13], i[2:0], r[9], 1'b0};
            @(posedge clk);
            en <= (i % 5) != 0;
            fw <= r[16];
            skip <= r[31:16] & 16'h0303;
            r = $random(seed);
            ext <= r[15:0];
            gpio <= r;
            r = $random(seed);
            pv <= r[24:0];
            r = $random(seed);
            pe <= r[24:0];
            wr(8'hE1, ra);
            wr(8'h9F, ~ra);
            wr(8'hE2, rb);
            rd(8'hE1, ra);
            rd(8'hE2, rb);
            rd(8'h9F, 8'h00);
            repeat (6) @(posedge clk);
            #1 model();
            chk_vec(placed, ep);
            chk_vec(25'(pin_oe), 25'(ee));
            chk_vec(25'(pin_out), 25'(eo));
            chk_vec(p_in, ei);
        end
        wrap_up();
    end
endmodule
